// *** rps_pkg.sv ***
// Shared constants and types for the rate-of-change-of-frequency stages
package rps_pkg;
    localparam int N_STAGE     = 8;         // Independent stages
    localparam int N_SG        = 8;         // Setting groups
    localparam int W_RATE      = 18;        // Signed rate, 0.001 Hz/s per LSB
    localparam int W_FREQ      = 16;        // Frequency, 0.01 Hz per LSB
    localparam int W_PU        = 10;        // Pick-up, 0.01 Hz/s per LSB
    localparam int W_MAX       = 13;        // Max allowed rate, 0.01 Hz/s per LSB
    localparam int W_DLY       = 19;        // Delay, 5 ms per LSB
    localparam int W_CNT       = 16;        // Cumulative counters
    localparam int W_RATIO     = 16;        // Ratio, 0.005 p.u. per LSB
    localparam int W_STAMP     = 32;        // Time stamp, 1 ms per LSB
    localparam int N_REC       = 12;        // Operation records kept
    localparam int HYST_MHZS   = 100;       // Release hysteresis in mHz/s
    localparam int PU_SCALE    = 10;        // 0.01 Hz/s to mHz/s
    localparam int RATIO_SCALE = 20;        // mHz/s over 0.01 Hz/s, in 0.005 p.u.
    localparam int CLK_NS      = 40;        // Core clock period
    localparam int MS_NS       = 1000000;   // Time stamp step
    localparam int MS_CYC      = MS_NS / CLK_NS;
    localparam int CYCLE_MS    = 5;         // Processing cycle and delay step
    localparam int PRE_MS      = 20;        // Pre-trigger look-back
    localparam int PRE_CYC     = PRE_MS / CYCLE_MS;
    localparam int DEF_PU      = 20;        // 0.2 Hz/s
    localparam int DEF_UF      = 4995;      // 49.95 Hz
    localparam int DEF_OF      = 5100;      // 51 Hz
    localparam int DEF_DLY     = 20;        // 0.1 s
    localparam int DEF_MAX     = 2000;      // 20 Hz/s
    localparam int EVT_ON_BIT  = 0;         // Store ON events
    localparam int EVT_OFF_BIT = 1;         // Store OFF events
    typedef enum logic [1:0] {RPS_RISING, RPS_FALLING, RPS_BOTH} rps_dir_type;
    typedef enum logic [1:0] {RPS_NORMAL, RPS_STARTED, RPS_TRIPPED, RPS_BLOCKED} rps_cond_type;
    typedef struct packed {
        logic [W_STAMP-1:0]       stamp;
        logic signed [W_RATE-1:0] pre_rate;
        logic [W_FREQ-1:0]        pre_freq;
        logic signed [W_RATE-1:0] rate;
        logic [W_FREQ-1:0]        freq;
        logic [2:0]               sg;
    } rps_rec_type;
endpackage

// *** rps_timebase.sv ***
// Millisecond stamp counter and processing-cycle tick
`timescale 1ns/1ps
`default_nettype none
module rps_timebase #(
    parameter int MS_CYC   = rps_pkg::MS_CYC,
    parameter int CYCLE_MS = rps_pkg::CYCLE_MS
) (
    input  wire logic                         i_core_clk,  // Core clock
    input  wire logic                         i_resetn,    // Sync reset, low
    output logic                              o_cyc_tick,  // One-cycle tick per cycle
    output logic [rps_pkg::W_STAMP-1:0]       o_stamp      // Milliseconds since reset
);
    typedef struct packed {
        logic [31:0]                  div;
        logic [7:0]                   ms;
        logic [rps_pkg::W_STAMP-1:0]  stamp;
        logic                         tick;
    } rps_tb_type;
    rps_tb_type s_q, s_d;

    // Elaboration check on divider parameters
    if (MS_CYC < 1 || CYCLE_MS < 1 || CYCLE_MS > 255) begin : g_bad_param
        $error("rps_timebase: bad divider parameters");
    end

    // Divide clock to ms, ms to processing cycles
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.div == 32'(MS_CYC - 1)) begin
            s_d.div = '0;
            s_d.stamp = s_q.stamp + 1'b1;
            if (s_q.ms == 8'(CYCLE_MS - 1)) begin
                s_d.ms = '0;
                s_d.tick = 1'b1;
            end else begin
                s_d.ms = s_q.ms + 8'h01;
            end
        end else begin
            s_d.div = s_q.div + 32'h0000_0001;
        end
    end

    // State register
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_cyc_tick = s_q.tick;
    assign o_stamp    = s_q.stamp;
endmodule
`default_nettype wire

// *** rps_top.sv ***
// Eight-stage rate-of-change-of-frequency protection
// What this block does
// - compare measured rate with stage pick-up
// - release only past 100 mHz/s hysteresis
// - frequency limits block operation near nominal
// - per-group stage enable, disabled after reset
// - direction selects rising, falling or both
// - selector turns frequency limits on
// - falling needs frequency below under-limit
// - rising needs frequency above over-limit
// - definite operate delay in 5 ms steps
// - start only while blocking is inactive
// - blocking input sampled every processing cycle
// - blocked pick-up gives blocked, no start
// - late blocking drops start, resets timer
// - blocking gives panel and stamped event
// - events on changes, ON/OFF store filter
// - events carry stamp and process data
// - condition readout normal/started/tripped/blocked
// - per-unit ratio readout, 0.005 resolution
// - measured rate readout in mHz/s
// - remaining and expected operate time readouts
// - excessive rate blocks the whole function
// - 1 ms stamps, instant start/trip share one
// - resettable start, trip, blocked counters
// - twelve latest operation records kept
`timescale 1ns/1ps
`default_nettype none
module rps_top #(
    parameter int N      = rps_pkg::N_STAGE,
    parameter int MS_CYC = rps_pkg::MS_CYC
) (
    input  wire logic                               i_core_clk,  // Core clock
    input  wire logic                               i_resetn,    // Sync reset, low
    input  wire logic signed [rps_pkg::W_RATE-1:0]  i_rate,      // Measured rate, mHz/s
    input  wire logic [rps_pkg::W_FREQ-1:0]         i_freq,      // Frequency, 0.01 Hz
    input  wire logic [2:0]                         i_active_sg, // Active setting group
    input  wire logic [7:0][N-1:0]                  i_sg_enable, // Stage enable per group
    input  wire logic [N-1:0][1:0]                  i_dir,       // Direction code
    input  wire logic [N-1:0]                       i_use_lim,   // Use frequency limits
    input  wire logic [N-1:0][rps_pkg::W_PU-1:0]    i_pickup,    // Pick-up, 0.01 Hz/s
    input  wire logic [N-1:0][rps_pkg::W_FREQ-1:0]  i_uf_lim,    // Under-limit, 0.01 Hz
    input  wire logic [N-1:0][rps_pkg::W_FREQ-1:0]  i_of_lim,    // Over-limit, 0.01 Hz
    input  wire logic [N-1:0][rps_pkg::W_DLY-1:0]   i_delay,     // Delay, 5 ms steps
    input  wire logic [rps_pkg::W_MAX-1:0]          i_max_rate,  // Max rate, 0.01 Hz/s
    input  wire logic [N-1:0]                       i_block,     // Blocking matrix input
    input  wire logic [1:0]                         i_evt_mode,  // Store ON / OFF events
    input  wire logic                               i_cnt_clear, // Clear counters
    input  wire logic [3:0]                         i_rec_sel,   // Record index, 0 newest
    output logic [N-1:0]                            o_start,     // Start outputs
    output logic [N-1:0]                            o_trip,      // Trip outputs
    output logic [N-1:0]                            o_blocked,   // Blocked outputs
    output logic [N-1:0][1:0]                       o_cond,      // Condition code
    output logic [N-1:0][rps_pkg::W_RATIO-1:0]      o_ratio,     // Rate / pick-up
    output logic signed [rps_pkg::W_RATE-1:0]       o_meas_rate, // Present rate
    output logic [N-1:0][rps_pkg::W_DLY:0]          o_remain,    // Signed time to trip
    output logic [N-1:0][rps_pkg::W_DLY-1:0]        o_exp_time,  // Expected operate time
    output logic [N-1:0][rps_pkg::W_CNT-1:0]        o_cnt_start, // Start count
    output logic [N-1:0][rps_pkg::W_CNT-1:0]        o_cnt_trip,  // Trip count
    output logic [N-1:0][rps_pkg::W_CNT-1:0]        o_cnt_blk,   // Blocked count
    output logic                                    o_evt_valid, // Event pulse
    output logic [3*N-1:0]                          o_evt_mask,  // Changed outputs stored
    output logic [3*N-1:0]                          o_evt_level, // New output levels
    output logic [rps_pkg::W_STAMP-1:0]             o_evt_stamp, // Event time, ms
    output logic signed [rps_pkg::W_RATE-1:0]       o_evt_rate,  // Rate at event
    output logic [rps_pkg::W_FREQ-1:0]              o_evt_freq,  // Frequency at event
    output logic                                    o_panel_evt, // Panel blocking notice
    output logic [3:0]                              o_rec_count, // Records held
    output var rps_pkg::rps_rec_type                o_rec        // Selected record
);
    localparam int WR = rps_pkg::W_RATE;
    localparam int WD = rps_pkg::W_DLY;
    localparam int WC = rps_pkg::W_CNT;

    typedef struct packed {
        logic [N-1:0]                          en;
        logic [N-1:0]                          pk;
        logic [N-1:0]                          start;
        logic [N-1:0]                          trip;
        logic [N-1:0]                          blk;
        rps_pkg::rps_cond_type [N-1:0]         cond;
        logic [N-1:0][WD-1:0]                  el;
        logic [N-1:0][WD:0]                    remain;
        logic [N-1:0][WD-1:0]                  exp_t;
        logic [N-1:0][rps_pkg::W_RATIO-1:0]    ratio;
        logic [N-1:0][WC-1:0]                  c_st;
        logic [N-1:0][WC-1:0]                  c_tr;
        logic [N-1:0][WC-1:0]                  c_bk;
        logic signed [WR-1:0]                  rate;
        logic [rps_pkg::PRE_CYC-1:0][WR-1:0]   h_rate;
        logic [rps_pkg::PRE_CYC-1:0][15:0]     h_freq;
        logic                                  ev_v;
        logic [3*N-1:0]                        ev_m;
        logic [3*N-1:0]                        ev_l;
        logic [rps_pkg::W_STAMP-1:0]           ev_t;
        logic signed [WR-1:0]                  ev_r;
        logic [15:0]                           ev_f;
        logic                                  panel;
        rps_pkg::rps_rec_type [rps_pkg::N_REC-1:0] rec;
        logic [3:0]                            wr;
        logic [3:0]                            cnt;
    } rps_state_type;
    rps_state_type s_q, s_d;

    logic                         cyc_tick;
    logic [rps_pkg::W_STAMP-1:0]  stamp;

    // Elaboration check; history shift needs two entries at least
    if (N < 1 || N > rps_pkg::N_STAGE || rps_pkg::PRE_CYC < 2) begin : g_bad_param
        $error("rps_top: stage count out of range");
    end

    // Stamp and processing cycle source
    rps_timebase #(.MS_CYC(MS_CYC), .CYCLE_MS(rps_pkg::CYCLE_MS)) u_tb (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .o_cyc_tick (cyc_tick),
        .o_stamp    (stamp)
    );

    // Absolute value of a rate, widened
    function automatic logic signed [WR+1:0] f_abs(input logic signed [WR-1:0] r);
        f_abs = (r < 0) ? -(WR+2)'(r) : (WR+2)'(r);
    endfunction

    // Rate as seen by the chosen direction
    function automatic logic signed [WR+1:0] f_metric(input logic signed [WR-1:0] r,
                                                     input logic [1:0] d);
        case (d)
            2'h0:    f_metric = (WR+2)'(r);
            2'h1:    f_metric = -(WR+2)'(r);
            default: f_metric = f_abs(r);
        endcase
    endfunction

    // Rate over pick-up in 0.005 p.u., saturated
    function automatic logic [15:0] f_ratio(input logic signed [WR+1:0] a,
                                            input logic [rps_pkg::W_PU-1:0] p);
        logic [31:0] q;
        q = 32'hFFFF_FFFF;
        if (p != '0) begin
            q = 32'(a) * 32'(rps_pkg::RATIO_SCALE) / 32'(p);
        end
        f_ratio = (q > 32'h0000_FFFF) ? 16'hFFFF : q[15:0];
    endfunction

    // Saturating counter step
    function automatic logic [WC-1:0] f_inc(input logic [WC-1:0] c, input logic hit);
        f_inc = (hit && c != '1) ? c + 1'b1 : c;
    endfunction

    // Stage evaluation once per processing cycle
    always_comb begin
        logic signed [WR+1:0] m;
        logic signed [WR+1:0] p;
        logic                 maxblk;
        logic                 perm;
        logic                 eff;
        logic                 st;
        logic [WD-1:0]        el;
        logic [3*N-1:0]       nw;
        logic [3*N-1:0]       od;
        m = '0;
        p = '0;
        perm = 1'b0;
        eff = 1'b0;
        st = 1'b0;
        el = '0;
        nw = '0;
        od = '0;
        s_d = s_q;
        s_d.ev_v = 1'b0;
        s_d.panel = 1'b0;
        // Whole function blocked on excessive rate
        maxblk = f_abs(i_rate) > (WR+2)'(32'(i_max_rate) * rps_pkg::PU_SCALE);
        if (cyc_tick) begin
            s_d.rate = i_rate;
            s_d.h_rate = {s_q.h_rate[rps_pkg::PRE_CYC-2:0], i_rate};
            s_d.h_freq = {s_q.h_freq[rps_pkg::PRE_CYC-2:0], i_freq};
            for (int k = 0; k < N; k++) begin
                s_d.en[k] = i_sg_enable[i_active_sg][k];
                m = f_metric(i_rate, i_dir[k]);
                p = (WR+2)'(32'(i_pickup[k]) * rps_pkg::PU_SCALE);
                // Pick-up with fixed release hysteresis
                if (s_q.pk[k]) begin
                    s_d.pk[k] = m >= p - (WR+2)'(rps_pkg::HYST_MHZS);
                end else begin
                    s_d.pk[k] = m >= p;
                end
                // Frequency permit window
                case (i_dir[k])
                    2'h0:    perm = i_freq > i_of_lim[k];
                    2'h1:    perm = i_freq < i_uf_lim[k];
                    default: perm = i_freq > i_of_lim[k] || i_freq < i_uf_lim[k];
                endcase
                perm = perm || !i_use_lim[k];
                eff = s_d.en[k] && s_d.pk[k] && perm;
                // Block sampled at the start of this cycle
                s_d.blk[k] = eff && (i_block[k] || maxblk);
                st = eff && !i_block[k] && !maxblk;
                s_d.start[k] = st;
                el = '0;
                if (st && s_q.start[k]) begin
                    el = (s_q.el[k] == '1) ? s_q.el[k] : s_q.el[k] + 1'b1;
                end
                s_d.el[k] = el;
                s_d.trip[k] = st && el >= i_delay[k];
                s_d.remain[k] = st ? (WD+1)'(i_delay[k]) - (WD+1)'(el) : '0;
                s_d.exp_t[k] = i_delay[k];
                s_d.ratio[k] = f_ratio(f_abs(i_rate), i_pickup[k]);
                if (s_d.blk[k]) begin
                    s_d.cond[k] = rps_pkg::RPS_BLOCKED;
                end else if (s_d.trip[k]) begin
                    s_d.cond[k] = rps_pkg::RPS_TRIPPED;
                end else if (st) begin
                    s_d.cond[k] = rps_pkg::RPS_STARTED;
                end else begin
                    s_d.cond[k] = rps_pkg::RPS_NORMAL;
                end
                s_d.c_st[k] = f_inc(s_q.c_st[k], st && !s_q.start[k]);
                s_d.c_tr[k] = f_inc(s_q.c_tr[k], s_d.trip[k] && !s_q.trip[k]);
                s_d.c_bk[k] = f_inc(s_q.c_bk[k], s_d.blk[k] && !s_q.blk[k]);
            end
            // One stamped event covers every stored change of this cycle
            nw = {s_d.blk, s_d.trip, s_d.start};
            od = {s_q.blk, s_q.trip, s_q.start};
            s_d.ev_m = (nw & ~od & {3*N{i_evt_mode[rps_pkg::EVT_ON_BIT]}})
                     | (~nw & od & {3*N{i_evt_mode[rps_pkg::EVT_OFF_BIT]}});
            s_d.ev_v = |s_d.ev_m;
            if (s_d.ev_v) begin
                s_d.ev_l = nw;
                s_d.ev_t = stamp;
                s_d.ev_r = i_rate;
                s_d.ev_f = i_freq;
            end
            s_d.panel = |(s_d.blk & ~s_q.blk);
            // Operation record on any new trip
            if (|(s_d.trip & ~s_q.trip)) begin
                s_d.rec[s_q.wr] = '{stamp, s_q.h_rate[rps_pkg::PRE_CYC-1],
                                    s_q.h_freq[rps_pkg::PRE_CYC-1], i_rate, i_freq,
                                    i_active_sg};
                s_d.wr = (s_q.wr == 4'(rps_pkg::N_REC - 1)) ? 4'h0 : s_q.wr + 4'h1;
                s_d.cnt = (s_q.cnt == 4'(rps_pkg::N_REC)) ? s_q.cnt : s_q.cnt + 4'h1;
            end
        end
        if (i_cnt_clear) begin
            s_d.c_st = '0;
            s_d.c_tr = '0;
            s_d.c_bk = '0;
        end
    end

    // State register
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Record read-back, newest first
    logic [4:0] rd_idx;
    always_comb begin
        rd_idx = 5'(s_q.wr) + 5'(rps_pkg::N_REC) - 5'h01 - 5'(i_rec_sel);
        if (rd_idx >= 5'(rps_pkg::N_REC)) begin
            rd_idx = rd_idx - 5'(rps_pkg::N_REC);
        end
        o_rec = (i_rec_sel < s_q.cnt) ? s_q.rec[rd_idx[3:0]] : '0;
    end

    // Outputs
    assign o_start     = s_q.start;
    assign o_trip      = s_q.trip;
    assign o_blocked   = s_q.blk;
    assign o_cond      = s_q.cond;
    assign o_ratio     = s_q.ratio;
    assign o_meas_rate = s_q.rate;
    assign o_remain    = s_q.remain;
    assign o_exp_time  = s_q.exp_t;
    assign o_cnt_start = s_q.c_st;
    assign o_cnt_trip  = s_q.c_tr;
    assign o_cnt_blk   = s_q.c_bk;
    assign o_evt_valid = s_q.ev_v;
    assign o_evt_mask  = s_q.ev_m;
    assign o_evt_level = s_q.ev_l;
    assign o_evt_stamp = s_q.ev_t;
    assign o_evt_rate  = s_q.ev_r;
    assign o_evt_freq  = s_q.ev_f;
    assign o_panel_evt = s_q.panel;
    assign o_rec_count = s_q.cnt;

    // Checks on stage 0 and shared logic
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_blk_tick;
        cyc_tick && i_block[0];
    endsequence
    sequence s_rise_pk;
        cyc_tick && !s_q.pk[0] && s_d.pk[0];
    endsequence

    property p_start_needs_pk;
        o_start[0] |-> s_q.pk[0] && s_q.en[0];
    endproperty
    a_start_needs_pk: assert property (p_start_needs_pk) else $error("start without pick-up");

    property p_release_hyst;
        cyc_tick && s_q.pk[0] && f_metric(i_rate, i_dir[0])
            >= $signed((WR+2)'(32'(i_pickup[0]) * rps_pkg::PU_SCALE)) - (WR+2)'(rps_pkg::HYST_MHZS)
            |=> s_q.pk[0];
    endproperty
    a_release_hyst: assert property (p_release_hyst) else $error("released inside hysteresis");

    property p_disabled;
        cyc_tick && !i_sg_enable[i_active_sg][0] |=> !o_start[0] && !o_blocked[0];
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled stage acted");

    property p_blocked;
        s_blk_tick |=> !o_start[0] && !o_trip[0];
    endproperty
    a_blocked: assert property (p_blocked) else $error("start under block");

    property p_late_block;
        o_start[0] ##0 s_blk_tick |=> !o_start[0] && s_q.el[0] == '0;
    endproperty
    a_late_block: assert property (p_late_block) else $error("late block kept start");

    // Max-rate condition for the checks
    logic maxblk_chk;
    assign maxblk_chk = f_abs(i_rate) > (WR+2)'(32'(i_max_rate) * rps_pkg::PU_SCALE);

    property p_maxrate;
        cyc_tick && maxblk_chk |=> !o_start[0];
    endproperty
    a_maxrate: assert property (p_maxrate) else $error("start above max rate");

    property p_trip_start;
        o_trip[0] |-> o_start[0] && s_q.el[0] >= i_delay[0];
    endproperty
    a_trip_start: assert property (p_trip_start) else $error("trip without delay");

    property p_pk_event;
        s_rise_pk ##0 (s_d.en[0] && !i_block[0] && !maxblk_chk && !i_use_lim[0])
            ##0 i_evt_mode[0] |=> o_evt_valid && o_evt_mask[0] && o_evt_stamp == $past(stamp);
    endproperty
    a_pk_event: assert property (p_pk_event) else $error("start ON event missing");

    property p_cond;
        o_blocked[0] |-> o_cond[0] == 2'h3;
    endproperty
    a_cond: assert property (p_cond) else $error("blocked condition code");

    property p_count;
        cyc_tick && !i_cnt_clear && s_d.start[0] && !s_q.start[0] && s_q.c_st[0] < 16'h00FF
            |=> o_cnt_start[0] == $past(s_q.c_st[0]) + 1'b1;
    endproperty
    a_count: assert property (p_count) else $error("start counter missed");
endmodule
`default_nettype wire

// *** rps_evt_sink.sv ***
// Event buffer model that takes every stored event
`timescale 1ns/1ps
`default_nettype none
module rps_evt_sink (
    input  wire logic        i_core_clk,  // Core clock
    input  wire logic        i_resetn,    // Sync reset, low
    input  wire logic        i_valid,     // Event pulse
    input  wire logic [23:0] i_mask,      // Stored changes
    output logic      [15:0] o_count,     // Events taken
    output logic      [23:0] o_last       // Last stored mask
);
    // One buffer entry per pulse, latest mask kept
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_count <= 16'h0000;
            o_last  <= 24'h000000;
        end else if (i_valid) begin
            o_count <= o_count + 16'h0001;
            o_last  <= i_mask;
        end
    end
endmodule
`default_nettype wire

// *** rps_top_test.sv ***
// Self-checking bench for the eight-stage rate protection
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; $display("wrong value %s exp %0h got %0h", n, e, a); end end
module rps_top_test;
    localparam logic H = 1'b1;
    localparam logic L = 1'b0;
    logic                    clk = 1'b0;
    logic                    resetn = 1'b0;
    logic signed [17:0]      rate = 18'h00000;
    logic [15:0]             freq = 16'h1388;
    logic [7:0][7:0]         sg_en = '0;
    logic [7:0][1:0]         dir = '0;
    logic [7:0]              use_lim = 8'h00;
    logic [7:0]              blk = 8'h00;
    logic                    clr = 1'b0;
    logic [7:0]              st, tr, bd;
    logic [7:0][1:0]         cond;
    logic [7:0][15:0]        ratio, cs, ct, cb;
    logic signed [17:0]      meas;
    logic [7:0][18:0]        expt;
    logic                    evt_v;
    logic [23:0]             evt_m, last_m;
    logic [15:0]             evt_n;
    logic [3:0]              rec_n;
    logic [2:0]              sg = 3'h0;
    logic [1:0]              evm = 2'h3;
    logic [3:0]              rsel = 4'h0;
    logic [7:0][19:0]        rem;
    logic [23:0]             lvl;
    logic signed [17:0]      erate;
    logic [15:0]             efreq;
    logic                    panel;
    int                      panel_n = 0;
    rps_pkg::rps_rec_type    rec;
    int                      fails = 0;
    int                      tests_run = 0;

    // Stage 0 under test, delay two cycles, pick-up 0.2 Hz/s
    rps_top #(.N(8), .MS_CYC(4)) dut (.i_core_clk(clk), .i_resetn(resetn), .i_rate(rate), .i_freq(freq),
        .i_active_sg(sg), .i_sg_enable(sg_en), .i_dir(dir), .i_use_lim(use_lim), .i_pickup({8{10'h014}}),
        .i_uf_lim({8{16'h1383}}), .i_of_lim({8{16'h13EC}}), .i_delay({8{19'h00002}}), .i_max_rate(13'h07D0),
        .i_block(blk), .i_evt_mode(evm), .i_cnt_clear(clr), .i_rec_sel(rsel), .o_start(st), .o_trip(tr),
        .o_blocked(bd), .o_cond(cond), .o_ratio(ratio), .o_meas_rate(meas), .o_remain(rem), .o_exp_time(expt),
        .o_cnt_start(cs), .o_cnt_trip(ct), .o_cnt_blk(cb), .o_evt_valid(evt_v), .o_evt_mask(evt_m),
        .o_evt_level(lvl), .o_evt_stamp(), .o_evt_rate(erate), .o_evt_freq(efreq), .o_panel_evt(panel),
        .o_rec_count(rec_n), .o_rec(rec));

    // Far-side event store
    rps_evt_sink sink (.i_core_clk(clk), .i_resetn(resetn), .i_valid(evt_v), .i_mask(evt_m), .o_count(evt_n),
        .o_last(last_m));

    // Panel notices seen
    always @(posedge clk) begin
        if (panel === 1'b1) begin
            panel_n <= panel_n + 1;
        end
    end

    // Core clock, 40 ns period
    initial begin
        forever #20 clk = ~clk;
    end

    // One processing cycle: apply inputs, check stage 0 after the tick
    task automatic run(input logic e, input logic [1:0] d, input logic l, input logic b,
                       input logic signed [17:0] r, input logic [15:0] f,
                       input logic xs, input logic xt, input logic xb);
        @(posedge clk);
        sg_en[0][0] <= e;
        dir[0] <= d;
        use_lim[0] <= l;
        blk[0] <= b;
        rate <= r;
        freq <= f;
        repeat (19) @(posedge clk);
        #1;
        `CHK("start", xs, st[0])
        `CHK("trip", xt, tr[0])
        `CHK("blocked", xb, bd[0])
        `CHK("cond", xb ? 2'h3 : xt ? 2'h2 : {1'b0, xs}, cond[0])
    endtask

    // Counts and verdict
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence, inputs placed mid-way between ticks
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        run(H, 2'h2, L, L, 18'h00000, 16'h1388, L, L, L);
        run(H, 2'h2, L, L, 18'h0012C, 16'h1388, H, L, L);
        `CHK("ratio", 16'h012C, ratio[0])
        `CHK("meas", 18'h0012C, meas)
        `CHK("exp", 19'h00002, expt[0])
        run(H, 2'h2, L, L, 18'h00096, 16'h1388, H, L, L);
        `CHK("remain", 20'h00001, rem[0])
        run(H, 2'h2, L, L, 18'h00096, 16'h1388, H, H, L);
        run(H, 2'h2, L, L, 18'h0005A, 16'h1388, L, L, L);
        run(H, 2'h2, L, H, 18'h0012C, 16'h1388, L, L, H);
        run(H, 2'h2, L, L, 18'h0012C, 16'h1388, H, L, L);
        run(H, 2'h2, L, H, 18'h0012C, 16'h1388, L, L, H);
        run(H, 2'h2, L, L, 18'h0012C, 16'h1388, H, L, L);
        run(H, 2'h0, L, L, 18'h3FED4, 16'h1388, L, L, L);
        run(H, 2'h1, L, L, 18'h3FED4, 16'h1388, H, L, L);
        run(H, 2'h1, H, L, 18'h3FED4, 16'h1388, L, L, L);
        run(H, 2'h1, H, L, 18'h3FED4, 16'h137E, H, L, L);
        run(H, 2'h0, H, L, 18'h0012C, 16'h1388, L, L, L);
        run(H, 2'h0, H, L, 18'h0012C, 16'h13F6, H, L, L);
        run(H, 2'h2, L, L, 18'h07530, 16'h1388, L, L, H);
        @(posedge clk);
        evm <= 2'h1;
        run(L, 2'h2, L, L, 18'h0012C, 16'h1388, L, L, L);
        @(posedge clk);
        sg <= 3'h1;
        run(H, 2'h2, L, L, 18'h0012C, 16'h1388, L, L, L);
        `CHK("cnt_start", 16'h0006, cs[0])
        `CHK("cnt_trip", 16'h0001, ct[0])
        `CHK("cnt_blk", 16'h0003, cb[0])
        `CHK("records", 4'h1, rec_n)
        `CHK("rec_rate", 18'h00096, rec.rate)
        `CHK("rec_sg", 3'h0, rec.sg)
        `CHK("evt_mask", 24'h010001, last_m)
        `CHK("evt_count", 16'h000E, evt_n)
        `CHK("evt_level", 24'h010000, lvl)
        `CHK("evt_rate", 18'h07530, erate)
        `CHK("evt_freq", 16'h1388, efreq)
        `CHK("panel", 3, panel_n)
        @(posedge clk);
        clr <= 1'b1;
        rsel <= 4'h1;
        repeat (2) @(posedge clk);
        #1;
        `CHK("cnt_clear", 16'h0000, cs[0])
        `CHK("rec_none", '0, rec)
        end_of_test();
    end
endmodule
`default_nettype wire
